// ---- shared/lin_uart_regs.svh ----
`ifndef LIN_UART_REGS_SVH
`define LIN_UART_REGS_SVH
// register offsets
`define REG_MODE 4'h0
`define REG_CKS 4'h1
`define REG_BAUD 4'h2
`define REG_AUX 4'h3
`define REG_TXB 4'h4
`define REG_RXB 4'h5
`define REG_STAT 4'h6
`define REG_ISC 4'h7
// mode register fields
`define MODE_POWER 7
`define MODE_TXE 6
`define MODE_RXE 5
`define MODE_LEN8 2
`define MODE_MASK 8'he4
// aux control register fields
`define AUX_SBRT 6
`define AUX_SBTT 5
`define AUX_SBL_HI 4
`define AUX_SBL_LO 2
`define AUX_DIR 1
`define AUX_INV 0
`define AUX_MASK 8'h5f
// status register fields
`define ST_OVR 0
`define ST_FE 1
`define ST_SBF 6
// input switch fields
`define ISC_ROUTE 1
`define ISC_PIN 7
`define ISC_MASK 8'h82
// reset values
`define RST_MODE 8'h04
`define RST_AUX 8'h00
`define RST_ISC 8'h00
`define RST_CKS 4'h0
`define RST_BAUD 8'hff
`define RST_BUF 8'hff
// timing counts
`define MAX_CLK_SEL 4'd11
`define BRK_BASE 5'd13
`define SBF_MIN 5'd11
`define CONT_GAP 2'd2
`endif

// ---- shared/lin_uart_pkg.sv ----
`default_nettype none
package lin_uart_pkg;
  typedef enum logic [2:0] {
    TX_IDLE = 3'b000,
    TX_START = 3'b001,
    TX_DATA = 3'b010,
    TX_STOP = 3'b011,
    TX_BRK = 3'b100,
    TX_GAP = 3'b101
  } tx_state_t;

  typedef enum logic [2:0] {
    RX_IDLE = 3'b000,
    RX_START = 3'b001,
    RX_DATA = 3'b010,
    RX_STOP = 3'b011,
    RX_BRK = 3'b100
  } rx_state_t;

  typedef struct packed {
    logic meta;
    logic stable;
  } sync_state_t;

  typedef struct packed {
    logic [7:0] cnt;
    logic tick;
  } baud_state_t;

  typedef struct packed {
    logic [7:0] mode_r;
    logic [3:0] clksel;
    logic [7:0] baud;
    logic [7:0] aux_r;
    logic [7:0] isc_r;
    logic [10:0] pre;
    logic txe_s;
    logic rxe_s;
    tx_state_t tx_st;
    logic [7:0] tx_buf;
    logic tx_pend;
    logic brk_req;
    logic [7:0] tx_sh;
    logic [4:0] tx_bits;
    logic tx_ph;
    logic [1:0] tx_gap;
    logic tx_line;
    logic tx_pin_q;
    logic tx_done;
    rx_state_t rx_st;
    logic [7:0] rx_sh;
    logic [4:0] rx_bits;
    logic rx_ph;
    logic [4:0] rx_low;
    logic [7:0] rx_buf;
    logic rx_full;
    logic ovr;
    logic fe;
    logic sbf_ok;
    logic rx_done;
    logic rx_prev;
    logic wake;
    logic cap_out;
    logic [7:0] rd_data;
  } core_state_t;
endpackage
`default_nettype wire

// ---- hdl/pin_sync.sv ----
`timescale 1ns/100ps
`default_nettype none
module pin_sync
  import lin_uart_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic async_in,
  output logic sync_out
);
  sync_state_t q;
  sync_state_t n;

  // two-stage synchroniser, idle high
  always_comb begin
    n = q;
    n.meta = async_in;
    n.stable = q.meta;
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      q <= '{meta: 1'b1, stable: 1'b1};
    end else begin
      q <= n;
    end
  end

  assign sync_out = q.stable;
endmodule // pin_sync
`default_nettype wire

// ---- hdl/baud_gen.sv ----
`timescale 1ns/100ps
`default_nettype none
module baud_gen
  import lin_uart_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic run,
  input wire logic base_tick,
  input wire logic [7:0] divisor,
  output logic half_tick
);
  baud_state_t q;
  baud_state_t n;
  logic [7:0] lim;

  // one pulse every divisor base clocks, every base clock for divisor 0; held at zero while idle
  always_comb begin
    n = q;
    n.tick = 1'b0;
    lim = (divisor == 8'h00) ? 8'h00 : divisor - 8'h01;
    if (!run) begin
      n.cnt = 8'h00;
    end else if (base_tick) begin // [RULE5]
      if (q.cnt >= lim) begin
        n.cnt = 8'h00;
        n.tick = 1'b1;
      end else begin
        n.cnt = q.cnt + 8'h01;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      q <= '{cnt: 8'h00, tick: 1'b0};
    end else begin
      q <= n;
    end
  end

  assign half_tick = q.tick;
endmodule // baud_gen
`default_nettype wire

// ---- hdl/lin_capable_async_serial.sv ----
// How it works
// [RULE1] character length of seven or eight data bits, both directions
// [RULE2] line rates up to 625 kbps are reachable
// [RULE3] transmitter and receiver run independently, full duplex
// [RULE4] one setting picks MSB-first or LSB-first for both directions
// [RULE5] 8-bit baud divider fed by one of twelve base clocks
// [RULE6] inversion acts on the transmit line only, receiver untouched
// [RULE7] hardware break of 13 to 20 bit times, length in aux bits 4..2
// [RULE8] received low of 11 bits or more sets flag and interrupt, else retry
// [RULE9] during break reception no errors, no buffer transfer, shifter holds FFH
// [RULE10] clock stop freezes state; power and enables clear reinitialise
// [RULE11] software sets power first, then transmit or receive enable
// [RULE12] enables synchronised to base clock; two base clocks before re-setting
// [RULE13] software waits one base clock after enabling before writing data
// [RULE14] back-to-back frames get two extra clocks between stop and start
// [RULE15] transmit done pulse after every frame, breaks included
// [RULE16] software sends 80H in eight-bit mode as wakeup
// [RULE17] falling edge on receive pin gives a wake edge pulse
// [RULE18] software re-tunes divider after sync field, re-arms break reception
// [RULE19] two select bits route receive to timer and choose receive pin
// [RULE20] power bit clear stops the unit to save power
// [RULE21] writing the transmit buffer starts a frame
// [RULE22] seven-bit LSB data lands in bits 0..6; overrun keeps buffer
// [RULE23] frame is low start, data, high stop; line idles high
`timescale 1ns/100ps
`default_nettype none
`include "lin_uart_regs.svh"
module lin_capable_async_serial
  import lin_uart_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic serial_rx_pin_a,
  input wire logic serial_rx_pin_b,
  input wire logic capture_timer_pin,
  output logic serial_tx_pin,
  output logic capture_timer_in,
  output logic wake_edge_irq,
  output logic tx_done_irq,
  output logic rx_done_irq
);
  localparam core_state_t RESET_STATE = '{
    mode_r: `RST_MODE, clksel: `RST_CKS, baud: `RST_BAUD, aux_r: `RST_AUX,
    isc_r: `RST_ISC, tx_st: TX_IDLE, tx_buf: `RST_BUF, tx_sh: `RST_BUF,
    tx_line: 1'b1, tx_pin_q: 1'b1, rx_st: RX_IDLE, rx_sh: `RST_BUF,
    rx_buf: `RST_BUF, rx_prev: 1'b1, cap_out: 1'b1, default: '0};

  core_state_t q;
  core_state_t n;
  logic rx_a;
  logic rx_b;
  logic cap_s;
  logic rx_in;
  logic tx_ht;
  logic rx_ht;
  logic base_tick;
  logic [3:0] sel;
  logic [10:0] mask;
  logic msb;
  logic len8;
  logic [7:0] sh_next;
  logic [7:0] asm_data;

  // pin synchronisers
  pin_sync u_sync_rx_a (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .async_in(serial_rx_pin_a),
    .sync_out(rx_a)
  );
  pin_sync u_sync_rx_b (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .async_in(serial_rx_pin_b),
    .sync_out(rx_b)
  );
  pin_sync u_sync_cap (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .async_in(capture_timer_pin),
    .sync_out(cap_s)
  );

  // independent bit timers for each direction
  baud_gen u_tx_baud ( // [RULE3]
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .run(q.tx_st != TX_IDLE && q.tx_st != TX_GAP),
    .base_tick(base_tick),
    .divisor(q.baud),
    .half_tick(tx_ht)
  );
  baud_gen u_rx_baud (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .run(q.rx_st != RX_IDLE),
    .base_tick(base_tick),
    .divisor(q.baud),
    .half_tick(rx_ht)
  );

  // base clock: ref_clk divided by 2^sel, sel 0..11; sel 0 gives 20 MHz for 625 kbps
  assign sel = (q.clksel > `MAX_CLK_SEL) ? `MAX_CLK_SEL : q.clksel; // [RULE5]
  assign mask = (11'h001 << sel) - 11'h001;
  assign base_tick = ((q.pre & mask) == mask); // [RULE2]
  assign rx_in = q.isc_r[`ISC_PIN] ? rx_b : rx_a; // [RULE19]
  assign msb = q.aux_r[`AUX_DIR]; // [RULE4]
  assign len8 = q.mode_r[`MODE_LEN8]; // [RULE1]

  // received word placed by length and order
  always_comb begin
    if (len8) begin
      asm_data = q.rx_sh;
    end else if (msb) begin
      asm_data = {q.rx_sh[6:0], 1'b0};
    end else begin
      asm_data = {1'b0, q.rx_sh[7:1]}; // [RULE22]
    end
  end

  // next state of the whole unit
  always_comb begin
    n = q;
    sh_next = msb ? {q.tx_sh[6:0], 1'b1} : {1'b1, q.tx_sh[7:1]};
    n.pre = q.pre + 11'h001;
    n.rd_data = 8'h00;
    n.tx_done = 1'b0;
    n.rx_done = 1'b0;
    n.rx_prev = rx_in;
    n.wake = q.rx_prev & ~rx_in; // [RULE17]
    n.cap_out = q.isc_r[`ISC_ROUTE] ? rx_in : cap_s; // [RULE19]
    // enables follow the base clock
    if (base_tick) begin // [RULE12]
      n.txe_s = q.mode_r[`MODE_POWER] & q.mode_r[`MODE_TXE];
      n.rxe_s = q.mode_r[`MODE_POWER] & q.mode_r[`MODE_RXE];
    end
    // reads and flag clears first, so hardware sets below win
    if (reg_rd) begin
      case (reg_addr)
        `REG_MODE: n.rd_data = q.mode_r;
        `REG_CKS: n.rd_data = {4'h0, q.clksel};
        `REG_BAUD: n.rd_data = q.baud;
        `REG_AUX: n.rd_data = q.aux_r;
        `REG_TXB: n.rd_data = q.tx_buf;
        `REG_RXB: begin
          n.rd_data = q.rx_buf;
          n.rx_full = 1'b0;
        end
        `REG_STAT: n.rd_data = {1'b0, q.sbf_ok, q.tx_st != TX_IDLE, q.tx_pend, q.rx_full, 1'b0, q.fe, q.ovr};
        `REG_ISC: n.rd_data = q.isc_r;
        default: n.rd_data = 8'h00;
      endcase
    end
    if (reg_wr && reg_addr == `REG_STAT) begin
      n.ovr = q.ovr & ~reg_wdata[`ST_OVR];
      n.fe = q.fe & ~reg_wdata[`ST_FE];
      n.sbf_ok = q.sbf_ok & ~reg_wdata[`ST_SBF];
    end
    // transmitter
    case (q.tx_st)
      TX_IDLE: begin
        n.tx_line = 1'b1; // [RULE23]
        n.tx_ph = 1'b0;
        if (q.brk_req) begin
          n.brk_req = 1'b0;
          n.tx_st = TX_BRK;
          n.tx_line = 1'b0;
          n.tx_bits = `BRK_BASE + {2'b00, q.aux_r[`AUX_SBL_HI:`AUX_SBL_LO]}; // [RULE7]
        end else if (q.tx_pend) begin
          n.tx_pend = 1'b0;
          n.tx_sh = q.tx_buf;
          n.tx_st = TX_START;
          n.tx_line = 1'b0; // [RULE21]
        end
      end
      TX_START: begin
        if (tx_ht) begin
          n.tx_ph = ~q.tx_ph;
          if (q.tx_ph) begin
            n.tx_st = TX_DATA;
            n.tx_bits = len8 ? 5'd8 : 5'd7; // [RULE1]
            n.tx_line = msb ? q.tx_sh[7] : q.tx_sh[0]; // [RULE4]
          end
        end
      end
      TX_DATA: begin
        if (tx_ht) begin
          n.tx_ph = ~q.tx_ph;
          if (q.tx_ph) begin
            n.tx_sh = sh_next;
            if (q.tx_bits == 5'd1) begin
              n.tx_st = TX_STOP;
              n.tx_line = 1'b1; // [RULE23]
            end else begin
              n.tx_bits = q.tx_bits - 5'd1;
              n.tx_line = msb ? sh_next[7] : sh_next[0];
            end
          end
        end
      end
      TX_BRK: begin
        if (tx_ht) begin
          n.tx_ph = ~q.tx_ph;
          if (q.tx_ph) begin
            if (q.tx_bits == 5'd1) begin
              n.tx_st = TX_STOP;
              n.tx_line = 1'b1;
            end else begin
              n.tx_bits = q.tx_bits - 5'd1;
            end
          end
        end
      end
      TX_STOP: begin
        if (tx_ht) begin
          n.tx_ph = ~q.tx_ph;
          if (q.tx_ph) begin
            n.tx_done = 1'b1; // [RULE15]
            n.tx_gap = 2'd0;
            n.tx_st = (q.tx_pend | q.brk_req) ? TX_GAP : TX_IDLE;
          end
        end
      end
      TX_GAP: begin
        n.tx_gap = q.tx_gap + 2'd1;
        if (q.tx_gap == `CONT_GAP - 2'd1) begin
          n.tx_st = TX_IDLE; // [RULE14]
        end
      end
      default: n.tx_st = TX_IDLE;
    endcase
    // receiver
    case (q.rx_st)
      RX_IDLE: begin
        n.rx_ph = 1'b0;
        if (!rx_in) begin
          n.rx_st = RX_START;
        end
      end
      RX_START: begin
        if (rx_ht) begin
          n.rx_ph = 1'b0;
          if (rx_in) begin
            n.rx_st = RX_IDLE;
          end else if (q.aux_r[`AUX_SBRT]) begin
            n.rx_st = RX_BRK;
            n.rx_low = 5'd1;
            n.rx_sh = `RST_BUF; // [RULE9]
          end else begin
            n.rx_st = RX_DATA;
            n.rx_bits = len8 ? 5'd8 : 5'd7;
          end
        end
      end
      RX_DATA: begin
        if (rx_ht) begin
          n.rx_ph = ~q.rx_ph;
          if (q.rx_ph) begin
            n.rx_sh = msb ? {q.rx_sh[6:0], rx_in} : {rx_in, q.rx_sh[7:1]}; // [RULE4]
            if (q.rx_bits == 5'd1) begin
              n.rx_st = RX_STOP;
            end else begin
              n.rx_bits = q.rx_bits - 5'd1;
            end
          end
        end
      end
      RX_STOP: begin
        if (rx_ht) begin
          n.rx_ph = ~q.rx_ph;
          if (q.rx_ph) begin
            n.rx_st = RX_IDLE;
            n.rx_done = 1'b1;
            if (!rx_in) begin
              n.fe = 1'b1;
            end
            if (q.rx_full) begin
              n.ovr = 1'b1; // [RULE22]
            end else begin
              n.rx_buf = asm_data;
              n.rx_full = 1'b1;
            end
          end
        end
      end
      RX_BRK: begin
        if (rx_ht) begin
          n.rx_ph = ~q.rx_ph;
          if (q.rx_ph) begin
            if (!rx_in) begin
              n.rx_low = (q.rx_low == 5'd31) ? q.rx_low : q.rx_low + 5'd1;
            end else begin
              n.rx_st = RX_IDLE;
              if (q.rx_low >= `SBF_MIN) begin // [RULE8]
                n.sbf_ok = 1'b1;
                n.rx_done = 1'b1;
                n.aux_r[`AUX_SBRT] = 1'b0;
              end
            end
          end
        end
      end
      default: n.rx_st = RX_IDLE;
    endcase
    // configuration and data writes
    if (reg_wr) begin
      case (reg_addr)
        `REG_MODE: n.mode_r = reg_wdata & `MODE_MASK;
        `REG_CKS: n.clksel = reg_wdata[3:0];
        `REG_BAUD: n.baud = reg_wdata;
        `REG_AUX: begin
          n.aux_r = reg_wdata & `AUX_MASK;
          if (reg_wdata[`AUX_SBTT] && q.txe_s) begin
            n.brk_req = 1'b1; // [RULE7]
          end
        end
        `REG_TXB: begin
          n.tx_buf = reg_wdata;
          if (q.txe_s) begin
            n.tx_pend = 1'b1; // [RULE21]
          end
        end
        `REG_ISC: n.isc_r = reg_wdata & `ISC_MASK;
        default: n.pre = n.pre;
      endcase
    end
    // disabled directions and stop mode reinitialise
    if (!q.txe_s) begin // [RULE10]
      n.tx_st = TX_IDLE;
      n.tx_line = 1'b1;
      n.tx_pend = 1'b0;
      n.brk_req = 1'b0;
      n.tx_ph = 1'b0;
      n.tx_done = 1'b0;
    end
    if (!q.rxe_s) begin
      n.rx_st = RX_IDLE;
      n.rx_sh = `RST_BUF;
      n.rx_ph = 1'b0;
      n.rx_done = 1'b0;
    end
    if (!q.mode_r[`MODE_POWER]) begin // [RULE20]
      n.ovr = 1'b0;
      n.fe = 1'b0;
      n.sbf_ok = 1'b0;
      n.rx_full = 1'b0;
    end
    n.tx_pin_q = n.tx_line ^ n.aux_r[`AUX_INV]; // [RULE6]
  end

  // single state register
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      q <= RESET_STATE;
    end else begin
      q <= n;
    end
  end

  assign reg_rdata = q.rd_data;
  assign serial_tx_pin = q.tx_pin_q;
  assign capture_timer_in = q.cap_out;
  assign wake_edge_irq = q.wake;
  assign tx_done_irq = q.tx_done;
  assign rx_done_irq = q.rx_done;

  // checks
  property p_idle_high;
    @(posedge ref_clk) disable iff (!rst_n)
    (q.tx_st == TX_IDLE && $past(q.tx_st) == TX_IDLE) |-> q.tx_line;
  endproperty
  a_idle_high: assert property (p_idle_high) else $error("tx line not idle high"); // [RULE23]

  property p_invert;
    @(posedge ref_clk) disable iff (!rst_n)
    (q.tx_st == TX_IDLE && $past(q.tx_st) == TX_IDLE) |-> (serial_tx_pin != q.aux_r[`AUX_INV]);
  endproperty
  a_invert: assert property (p_invert) else $error("tx inversion wrong"); // [RULE6]

  property p_break_len;
    @(posedge ref_clk) disable iff (!rst_n)
    (q.tx_st == TX_BRK && $past(q.tx_st) == TX_IDLE) |->
      (q.tx_bits >= 5'd13 && q.tx_bits <= 5'd20 && !q.tx_line);
  endproperty
  a_break_len: assert property (p_break_len) else $error("break length out of range"); // [RULE7]

  property p_done_after_stop;
    @(posedge ref_clk) disable iff (!rst_n)
    tx_done_irq |-> ($past(q.tx_st) == TX_STOP && q.tx_line);
  endproperty
  a_done_after_stop: assert property (p_done_after_stop) else $error("tx done without stop"); // [RULE15]

  property p_sbf_hold;
    @(posedge ref_clk) disable iff (!rst_n)
    (q.rx_st == RX_BRK) |-> (q.rx_sh == 8'hff && $stable(q.rx_buf) && !$rose(q.ovr));
  endproperty
  a_sbf_hold: assert property (p_sbf_hold) else $error("break reception touched data"); // [RULE9]

  property p_sbf_len;
    @(posedge ref_clk) disable iff (!rst_n)
    ($rose(q.sbf_ok) && $past(q.mode_r[`MODE_POWER])) |-> ($past(q.rx_low) >= 5'd11 && rx_done_irq);
  endproperty
  a_sbf_len: assert property (p_sbf_len) else $error("short break accepted"); // [RULE8]

  property p_seven_lsb;
    @(posedge ref_clk) disable iff (!rst_n)
    ($rose(q.rx_full) && !$past(len8) && !$past(msb)) |-> !q.rx_buf[7];
  endproperty
  a_seven_lsb: assert property (p_seven_lsb) else $error("seven-bit msb not zero"); // [RULE22]

  property p_overrun_keep;
    @(posedge ref_clk) disable iff (!rst_n)
    $rose(q.ovr) |-> $stable(q.rx_buf);
  endproperty
  a_overrun_keep: assert property (p_overrun_keep) else $error("buffer changed on overrun"); // [RULE22]

  property p_gap;
    @(posedge ref_clk) disable iff (!rst_n || !q.txe_s)
    (q.tx_st == TX_GAP && $past(q.tx_st) == TX_STOP) |-> (q.tx_st == TX_GAP)[*2] ##1 (q.tx_st == TX_IDLE);
  endproperty
  a_gap: assert property (p_gap) else $error("continuous gap not two clocks"); // [RULE14]

  property p_enable_sync;
    @(posedge ref_clk) disable iff (!rst_n)
    (q.txe_s != $past(q.txe_s)) |-> $past(base_tick);
  endproperty
  a_enable_sync: assert property (p_enable_sync) else $error("enable changed off base clock"); // [RULE12]

  property p_stop_mode;
    @(posedge ref_clk) disable iff (!rst_n)
    (!q.mode_r[`MODE_POWER] && !q.txe_s && !q.rxe_s) |=> (q.tx_st == TX_IDLE && q.rx_st == RX_IDLE);
  endproperty
  a_stop_mode: assert property (p_stop_mode) else $error("unit active while stopped"); // [RULE20]
endmodule // lin_capable_async_serial
`default_nettype wire

// ---- testbench/remote_node.sv ----
`timescale 1ns/100ps
`default_nettype none
module remote_node #(
  parameter int BIT_CYC = 16
) (
  input wire logic ref_clk,
  input wire logic tx_line,
  output logic rx_line
);
  int low_run = 0;
  int t;
  int k;
  logic [8:0] got = '0;
  initial rx_line = 1'b1;
  // measures each low period in clock cycles
  always begin
    @(negedge tx_line);
    t = 0;
    while (tx_line === 1'b0 && t < 4000) begin
      @(posedge ref_clk);
      t++;
    end
    low_run = t - 1; // last pass already saw the first high cycle
  end
  // mid-bit sampling, lsb first, stop bit in got[8]
  always begin
    @(negedge tx_line);
    repeat (BIT_CYC / 2) @(posedge ref_clk);
    for (k = 0; k < 9; k++) begin
      repeat (BIT_CYC) @(posedge ref_clk);
      got[k] = tx_line;
    end
  end
  // drives n bits lsb first, one bit time each
  task automatic bits(input logic [15:0] v, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge ref_clk);
      rx_line <= v[i];
      repeat (BIT_CYC - 1) @(posedge ref_clk);
    end
  endtask
  // start, data, stop
  task automatic frame(input logic [7:0] d, input int n);
    bits((16'h1 << (n + 1)) | (16'(d) << 1), n + 2);
  endtask
  // low period then back to idle high
  task automatic low(input int n);
    bits(16'h0, n);
    bits(16'h1, 1);
  endtask
endmodule // remote_node
`default_nettype wire

// ---- testbench/lin_capable_async_serial_tb_top.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "lin_uart_regs.svh"
module lin_capable_async_serial_tb_top;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] reg_addr = '0;
  logic [7:0] reg_wdata = '0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic pin_b = 1'b1;
  logic cap_pin = 1'b1;
  logic [7:0] reg_rdata;
  logic rx_a, tx_pin, cap_in, wake_irq, txd_irq, rxd_irq;
  int fails = 0;
  int n_tests = 0;
  int n_txd = 0;
  int n_rxd = 0;
  int n_wake = 0;
  int cyc = 0;
  int t_prev = 0;
  int t_last = 0;
  localparam int BIT_CYC = 16; // two times divisor 8, base clock at ref_clk
  int r0, w0;
  logic [7:0] rst_v [9] = '{8'h04, 8'h00, 8'hff, 8'h00, 8'hff, 8'hff, 8'h00, 8'h00, 8'h00};

  lin_capable_async_serial u_dut (
    .ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .serial_rx_pin_a(rx_a),
    .serial_rx_pin_b(pin_b), .capture_timer_pin(cap_pin), .serial_tx_pin(tx_pin),
    .capture_timer_in(cap_in), .wake_edge_irq(wake_irq), .tx_done_irq(txd_irq), .rx_done_irq(rxd_irq)
  );
  remote_node #(.BIT_CYC(BIT_CYC)) u_node (.ref_clk(ref_clk), .tx_line(tx_pin), .rx_line(rx_a));

  // 20 MHz clock
  always #25 ref_clk = ~ref_clk;
  // counts the one-cycle event pulses
  always @(posedge ref_clk) begin
    cyc++;
    if (txd_irq === 1'b1) begin
      n_txd++;
      t_prev = t_last;
      t_last = cyc;
    end
    if (rxd_irq === 1'b1) n_rxd++;
    if (wake_irq === 1'b1) n_wake++;
  end

  task complete_run;
    $display("comparisons=%0d mismatches=%0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task check(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  // read data stand in the cycle after the strobe
  task rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 check(reg_rdata, exp);
  endtask
  task automatic wait_for(ref int c, input int target);
    for (int i = 0; i < 6000 && c < target; i++) @(posedge ref_clk);
    if (c < target) begin
      fails++;
      complete_run();
    end
  endtask

  initial begin
    repeat (5) @(posedge ref_clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 9; i++) rd(i, rst_v[i]);
    $display("test reset done");
    // base clock sel 0, divisor 8, power before enables
    wr(`REG_CKS, 8'h00);
    wr(`REG_BAUD, 8'h08);
    wr(`REG_MODE, 8'h80);
    wr(`REG_MODE, 8'he4);
    repeat (4) @(posedge ref_clk);
    wr(`REG_TXB, 8'ha5);
    wait_for(n_txd, 1);
    // last low of a5 is one data bit
    check(8'(u_node.low_run), 8'(BIT_CYC));
    wr(`REG_TXB, 8'ha5);
    wait_for(n_txd, 2);
    check(u_node.got[7:0], 8'ha5);
    check(8'(u_node.got[8]), 8'h01);
    check(8'(tx_pin), 8'h01);
    // back-to-back frames, second byte pending
    wr(`REG_TXB, 8'h3c);
    @(posedge ref_clk);
    wr(`REG_TXB, 8'h96);
    wait_for(n_txd, 4);
    check(u_node.got[7:0], 8'h96);
    check(8'(t_last - t_prev == 10 * BIT_CYC + 2 + `CONT_GAP), 8'h01);
    wr(`REG_TXB, 8'h80);
    wait_for(n_txd, 5);
    check(u_node.got[7:0], 8'h80);
    wr(`REG_AUX, 8'h02);
    wr(`REG_TXB, 8'h1e);
    wait_for(n_txd, 6);
    check(u_node.got[7:0], 8'h78);
    $display("test tx done");
    // every break length code
    for (int i = 0; i < 8; i++) begin
      wr(`REG_AUX, 8'h20 | 8'(i << 2));
      wait_for(n_txd, 7 + i);
      check(8'((u_node.low_run + BIT_CYC / 2) / BIT_CYC), 8'(13 + i));
    end
    $display("test break tx done");
    // inverted transmit line, receiver stays plain
    wr(`REG_AUX, 8'h01);
    repeat (4) @(posedge ref_clk);
    check(8'(tx_pin), 8'h00);
    u_node.frame(8'hc3, 8);
    wait_for(n_rxd, 1);
    rd(`REG_RXB, 8'hc3);
    check(8'(n_wake > 0), 8'h01);
    wr(`REG_AUX, 8'h00);
    // seven-bit reception, then overrun
    wr(`REG_MODE, 8'he0);
    repeat (4) @(posedge ref_clk);
    u_node.frame(8'hd5, 7);
    wait_for(n_rxd, 2);
    rd(`REG_RXB, 8'h55);
    u_node.frame(8'h11, 7);
    u_node.frame(8'h22, 7);
    rd(`REG_STAT, 8'h09);
    rd(`REG_RXB, 8'h11);
    wr(`REG_STAT, 8'h01);
    $display("test rx done");
    // break reception, short one refused first
    wr(`REG_MODE, 8'he4);
    wr(`REG_AUX, 8'h40);
    r0 = n_rxd;
    u_node.low(8);
    repeat (2 * BIT_CYC) @(posedge ref_clk);
    check(8'(n_rxd - r0), 8'h00);
    rd(`REG_AUX, 8'h40);
    u_node.low(12);
    wait_for(n_rxd, r0 + 1);
    rd(`REG_STAT, 8'h40);
    rd(`REG_AUX, 8'h00);
    rd(`REG_RXB, 8'h11);
    // enables off with power kept on, divider re-tuned, break reception armed again
    wr(`REG_MODE, 8'h80);
    wr(`REG_BAUD, 8'h08);
    wr(`REG_MODE, 8'he4);
    wr(`REG_AUX, 8'h40);
    rd(`REG_BAUD, 8'h08);
    rd(`REG_AUX, 8'h40);
    $display("test break rx done");
    // input switch routing
    cap_pin <= 1'b0;
    wr(`REG_ISC, 8'h00);
    repeat (4) @(posedge ref_clk);
    check(8'(cap_in), 8'h00);
    wr(`REG_ISC, 8'h02);
    repeat (4) @(posedge ref_clk);
    check(8'(cap_in), 8'h01);
    w0 = n_wake;
    pin_b <= 1'b0;
    wr(`REG_ISC, 8'h82);
    repeat (4) @(posedge ref_clk);
    check(8'(cap_in), 8'h00);
    check(8'(n_wake > w0), 8'h01);
    // power off clears flags
    wr(`REG_MODE, 8'h00);
    rd(`REG_STAT, 8'h00);
    $display("test misc done");
    complete_run();
  end
endmodule // lin_capable_async_serial_tb_top
`default_nettype wire
